// >>> core/ioc_map.svh
/*
  Register offsets, field positions, reset values and counts for the
  three-phase instantaneous overcurrent block.
  Assumes an 8-bit APB byte address and 32-bit data words.
*/
// How it works
// - an operation setting selects off, peak or fundamental, resets to off, and off gives no trips.
// - the start current is a percent of rated current from 20 to 3000 in steps of 1, default 200.
// - while the doubling input is high the phases are compared with twice the start current.
// - while the disable input is high every trip output goes low at the next edge with ce high and stays low whatever the currents.
// - each phase trips on its own, with no added delay, when its value is above the threshold.
// - peak mode compares peak values and fundamental mode compares fundamental rms values.
// - a peak value is taken separately for each phase from its own sample stream.
// - there are three separate trip outputs, one for each phase.
// - a general trip is high whenever at least one phase trip is high.
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IOC_ADDR_CONTROL   8'h00
`define IOC_ADDR_THRESHOLD 8'h04
`define IOC_ADDR_STATUS    8'h08
`define IOC_ADDR_PEAK_A    8'h0C
`define IOC_ADDR_PEAK_B    8'h10
`define IOC_ADDR_PEAK_C    8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define IOC_CTRL_MODE_MSB  1
`define IOC_THR_MSB        11
`define IOC_STAT_GEN_BIT   3
`define IOC_STAT_DIS_BIT   4
`define IOC_STAT_DBL_BIT   5

// ---------------------------------------------------------------
// reset values, limits and counts
// ---------------------------------------------------------------
`define IOC_THR_MIN        12'h014
`define IOC_THR_MAX        12'hBB8
`define IOC_THR_RESET      12'h0C8
`define IOC_WINDOW_LAST    5'h13

`endif

// >>> core/ioc_pkg.sv
/*
  Types shared by the overcurrent block: operation modes and the
  per-phase carriers for samples and fundamental rms values.
  Assumes phase a sits in the low bits of each carrier.
*/
package ioc_pkg;

  // operation setting, reset value is off
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PEAK,
    MODE_FUND
  } mode_e;

  // signed instantaneous samples, percent of rated current
  typedef struct packed {
    logic signed [15:0] c;
    logic signed [15:0] b;
    logic signed [15:0] a;
  } sample_set_s;

  // fundamental rms values, percent of rated current
  typedef struct packed {
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
  } rms_set_s;

  typedef logic [2:0][15:0] phase_word_t;

endpackage : ioc_pkg

// >>> core/three_phase_instant_overcurrent.sv
/*
  Three-phase instantaneous overcurrent decision with an APB slave.
  Assumes samples, rms values, disable and doubling inputs come from
  logic on clk; all values share one scale, percent of rated current.
*/
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ioc_map.svh"

module three_phase_instant_overcurrent
(
  // clock, reset and clock enable
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // sampled currents and fundamental values
  input  wire ioc_pkg::sample_set_s currentSample,
  input  wire logic                 sampleValid,
  input  wire ioc_pkg::rms_set_s    fundamentalRms,
  input  wire logic                 rmsValid,
  // binary status inputs
  input  wire logic                 disableInput,
  input  wire logic                 thresholdDoubleInput,
  // trip outputs
  output logic                      tripPhaseA,
  output logic                      tripPhaseB,
  output logic                      tripPhaseC,
  output logic                      generalTrip
);
  import ioc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  mode_e       modeReg;
  mode_e       modeNext;
  logic [11:0] thrReg;
  logic [11:0] thrNext;
  logic [31:0] prdataReg;
  logic [31:0] prdataNext;
  logic        errReg;
  logic        errNext;
  logic        capReg;
  logic        capNext;
  phase_word_t runMaxReg;
  phase_word_t runMaxNext;
  phase_word_t lastMaxReg;
  phase_word_t lastMaxNext;
  phase_word_t rmsReg;
  phase_word_t rmsNext;
  logic [4:0]  cntReg;
  logic [4:0]  cntNext;
  logic [2:0]  tripReg;
  logic [2:0]  tripNext;
  logic        genReg;
  logic        genNext;
  phase_word_t sampleRaw;
  phase_word_t sampleMag;
  phase_word_t sampleMax;
  phase_word_t peakVal;
  phase_word_t selVal;
  logic [15:0] effThr;
  logic [15:0] dblThr;
  logic [15:0] baseThr;
  logic        active;
  logic        doWrite;
  logic [31:0] readMux;
  logic        readErr;

  assign sampleRaw = currentSample;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // the answer comes one cycle after a captured setup, so a frozen
  // clock enable stalls the transfer instead of losing it
  assign pready  = ce & penable & capReg;
  assign pslverr = pready & errReg;
  assign prdata  = prdataReg;
  assign doWrite = psel & pwrite & pready & ~errReg;

  // read decode, unmapped offsets answer zero with an error
  always_comb
  begin
    readMux = 32'h0000_0000;
    readErr = 1'b0;
    unique case (paddr)
      `IOC_ADDR_CONTROL:
        readMux[`IOC_CTRL_MODE_MSB:0] = modeReg;
      `IOC_ADDR_THRESHOLD:
        readMux[`IOC_THR_MSB:0] = thrReg;
      `IOC_ADDR_STATUS:
      begin
        readMux[2:0] = tripReg;
        readMux[`IOC_STAT_GEN_BIT] = genReg;
        readMux[`IOC_STAT_DIS_BIT] = disableInput;
        readMux[`IOC_STAT_DBL_BIT] = thresholdDoubleInput;
      end
      `IOC_ADDR_PEAK_A:
        readMux[15:0] = peakVal[0];
      `IOC_ADDR_PEAK_B:
        readMux[15:0] = peakVal[1];
      `IOC_ADDR_PEAK_C:
        readMux[15:0] = peakVal[2];
      default:
        readErr = 1'b1;
    endcase
  end

  // capture read data in the setup cycle, apply writes at the answer
  always_comb
  begin
    capNext    = psel & ~(penable & capReg);
    prdataNext = prdataReg;
    errNext    = errReg;
    modeNext   = modeReg;
    thrNext    = thrReg;
    if (psel & ~capReg)
    begin
      prdataNext = readMux;
      errNext    = readErr;
    end
    if (doWrite && paddr == `IOC_ADDR_CONTROL)
    begin
      // an unused mode code falls back to off
      unique case (pwdata[`IOC_CTRL_MODE_MSB:0])
        2'h1:    modeNext = MODE_PEAK;
        2'h2:    modeNext = MODE_FUND;
        default: modeNext = MODE_OFF;
      endcase
    end
    if (doWrite && paddr == `IOC_ADDR_THRESHOLD)
    begin
      // out of range settings clamp to the nearest limit
      if (pwdata < {20'h00000, `IOC_THR_MIN})
        thrNext = `IOC_THR_MIN;
      else if (pwdata > {20'h00000, `IOC_THR_MAX})
        thrNext = `IOC_THR_MAX;
      else
        thrNext = pwdata[`IOC_THR_MSB:0];
    end
  end

  // bus and settings registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      capReg    <= 1'b0;
      prdataReg <= 32'h0000_0000;
      errReg    <= 1'b0;
      modeReg   <= MODE_OFF;
      thrReg    <= `IOC_THR_RESET;
    end
    else if (ce)
    begin
      capReg    <= capNext;
      prdataReg <= prdataNext;
      errReg    <= errNext;
      modeReg   <= modeNext;
      thrReg    <= thrNext;
    end
  end

  // ---------------------------------------------------------------
  // peak selection and rms hold
  // ---------------------------------------------------------------
  // per phase magnitude and peak; the peak spans the current and the
  // previous window so it never collapses at a window boundary
  for (genvar i = 0; i < 3; i++)
  begin : g_peak
    assign sampleMag[i] = sampleRaw[i][15] ?
                          16'(~sampleRaw[i] + 16'h0001) :
                          sampleRaw[i];
    assign sampleMax[i] = (sampleMag[i] > runMaxReg[i]) ?
                          sampleMag[i] : runMaxReg[i];
    assign peakVal[i]   = (runMaxReg[i] > lastMaxReg[i]) ?
                          runMaxReg[i] : lastMaxReg[i];

    peak_covers_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && sampleValid) |=> peakVal[i] >= $past(sampleMag[i]))
      else $error("peak below the latest sample magnitude");
  end

  // window counter and running maxima
  always_comb
  begin
    runMaxNext  = runMaxReg;
    lastMaxNext = lastMaxReg;
    cntNext     = cntReg;
    rmsNext     = rmsReg;
    if (sampleValid)
    begin
      if (cntReg == `IOC_WINDOW_LAST)
      begin
        lastMaxNext = sampleMax;
        runMaxNext  = '0;
        cntNext     = 5'h00;
      end
      else
      begin
        runMaxNext = sampleMax;
        cntNext    = cntReg + 5'h01;
      end
    end
    // the fundamental values are computed upstream and only held here
    if (rmsValid)
      rmsNext = fundamentalRms;
  end

  // peak and rms registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      runMaxReg  <= '0;
      lastMaxReg <= '0;
      cntReg     <= 5'h00;
      rmsReg     <= '0;
    end
    else if (ce)
    begin
      runMaxReg  <= runMaxNext;
      lastMaxReg <= lastMaxNext;
      cntReg     <= cntNext;
      rmsReg     <= rmsNext;
    end
  end

  // ---------------------------------------------------------------
  // instantaneous decision
  // ---------------------------------------------------------------
  // thresholds widened to the value width, doubling cannot overflow
  assign baseThr = {4'h0, thrReg};
  assign dblThr  = {3'h0, thrReg, 1'b0};
  assign effThr  = thresholdDoubleInput ? dblThr : baseThr;
  assign active  = (modeReg != MODE_OFF) & ~disableInput;

  // per phase selection and comparison, no delay beyond the register
  for (genvar i = 0; i < 3; i++)
  begin : g_decide
    assign selVal[i] = (modeReg == MODE_PEAK) ?
                       peakVal[i] : rmsReg[i];
    assign tripNext[i] = active & (selVal[i] > effThr);

    trip_sets_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && active && !thresholdDoubleInput && selVal[i] > baseThr)
      |=> tripReg[i])
      else $error("phase trip missing above the start current");

    double_holds_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && thresholdDoubleInput && selVal[i] <= dblThr)
      |=> !tripReg[i])
      else $error("phase trip below the doubled start current");

    trip_clears_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && selVal[i] <= effThr) |=> !tripReg[i])
      else $error("phase trip held at or below the threshold");

    fund_select_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && modeReg == MODE_FUND && !disableInput &&
       rmsReg[i] > effThr) |=> tripReg[i])
      else $error("fundamental mode ignored the rms value");

    peak_select_a: assert property (
      @(posedge clk) disable iff (reset)
      (ce && modeReg == MODE_PEAK && !disableInput &&
       peakVal[i] > effThr) |=> tripReg[i])
      else $error("peak mode ignored the peak value");
  end

  // general trip follows the same next values, so the two never skew
  always_comb
  begin
    genNext = |tripNext;
  end

  // trip registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tripReg <= 3'h0;
      genReg  <= 1'b0;
    end
    else if (ce)
    begin
      tripReg <= tripNext;
      genReg  <= genNext;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign tripPhaseA  = tripReg[0];
  assign tripPhaseB  = tripReg[1];
  assign tripPhaseC  = tripReg[2];
  assign generalTrip = genReg;

  // ---------------------------------------------------------------
  // checks on modes, limits and outputs
  // ---------------------------------------------------------------
  off_no_trip_a: assert property (
    @(posedge clk) disable iff (reset)
    (ce && modeReg == MODE_OFF) |=> tripReg == 3'h0 && !genReg)
    else $error("trip raised while the function is off");

  thr_range_a: assert property (
    @(posedge clk) disable iff (reset)
    thrReg >= `IOC_THR_MIN && thrReg <= `IOC_THR_MAX)
    else $error("start current setting out of range");

  disable_blocks_a: assert property (
    @(posedge clk) disable iff (reset)
    (ce && disableInput) |=> tripReg == 3'h0)
    else $error("trip raised while disabled");

  general_or_a: assert property (
    @(posedge clk) disable iff (reset)
    generalTrip == (tripPhaseA | tripPhaseB | tripPhaseC))
    else $error("general trip differs from the phase trips");

  trips_frozen_a: assert property (
    @(posedge clk) disable iff (reset)
    !ce |=> $stable(tripReg))
    else $error("trips moved while the clock enable was low");

endmodule : three_phase_instant_overcurrent

// >>> tb/ioc_source_model.sv
/*
  Upstream source model: current sampling and fundamental rms stage.
  Assumes the bench asks for one sample set or rms set per request.
*/
`timescale 1ns/1ps

module ioc_source_model
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // requests from the bench
  input  wire logic                 loadSample,
  input  wire ioc_pkg::sample_set_s sampleIn,
  input  wire logic                 loadRms,
  input  wire ioc_pkg::rms_set_s    rmsIn,
  // stream toward the block
  output ioc_pkg::sample_set_s      currentSample,
  output logic                      sampleValid,
  output ioc_pkg::rms_set_s         fundamentalRms,
  output logic                      rmsValid
);
  import ioc_pkg::*;

  // ---------------------------------------------------------------
  // one strobe per request, data launched after the edge
  // ---------------------------------------------------------------
  // outside a strobe the lines toggle, so a stale value never helps
  always_ff @(posedge clk)
  begin
    sampleValid    <= loadSample & ~reset;
    rmsValid       <= loadRms & ~reset;
    currentSample  <= reset ? '0 : (loadSample ? sampleIn : ~currentSample);
    fundamentalRms <= reset ? '0 : (loadRms ? rmsIn : ~fundamentalRms);
  end
endmodule : ioc_source_model

// >>> tb/test_three_phase_instant_overcurrent.sv
/*
  Self-checking bench for the three-phase overcurrent block.
  Assumes zero-wait APB answers may stretch; ce drops only once.
*/
`timescale 1ns/1ps
`include "ioc_map.svh"

module test_three_phase_instant_overcurrent;
  import ioc_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr;
  logic        sampleReq = 1'b0, rmsReq = 1'b0;
  sample_set_s sampleData = '0, currentSample;
  rms_set_s    rmsData = '0, fundamentalRms;
  logic        sampleValid, rmsValid;
  logic        disableInput = 1'b0, thresholdDoubleInput = 1'b0;
  logic        tripPhaseA, tripPhaseB, tripPhaseC, generalTrip;
  int          errCount = 0, checkCount = 0, cycles = 0;

  always #20 clk = ~clk;

  three_phase_instant_overcurrent u_dut (.clk(clk), .reset(reset),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .currentSample(currentSample),
    .sampleValid(sampleValid), .fundamentalRms(fundamentalRms),
    .rmsValid(rmsValid), .disableInput(disableInput),
    .thresholdDoubleInput(thresholdDoubleInput), .tripPhaseA(tripPhaseA),
    .tripPhaseB(tripPhaseB), .tripPhaseC(tripPhaseC),
    .generalTrip(generalTrip));

  ioc_source_model u_src (.clk(clk), .reset(reset), .loadSample(sampleReq),
    .sampleIn(sampleData), .loadRms(rmsReq), .rmsIn(rmsData),
    .currentSample(currentSample), .sampleValid(sampleValid),
    .fundamentalRms(fundamentalRms), .rmsValid(rmsValid));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task finish_test;
    $display("checks %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task check(input string name, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // trips packed as general, c, b, a
  task check_trips(input logic [3:0] exp);
    check("trips", {28'h0000000, generalTrip, tripPhaseC, tripPhaseB,
      tripPhaseA}, {28'h0000000, exp});
  endtask : check_trips

  // a hang counts as a mismatch and ends the run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errCount++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // apb master and stimulus tasks
  // ---------------------------------------------------------------
  // request held until pready is seen high at a rising edge
  task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0);
    check(name, rdata, e);
  endtask : rd_chk

  // settings act one edge later; wait a little margin
  task settle;
    repeat (3) @(posedge clk);
  endtask : settle

  task send_sample(input logic [47:0] s);
    @(posedge clk);
    sampleReq <= 1'b1;
    sampleData <= s;
    @(posedge clk);
    sampleReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send_sample

  task send_rms(input logic [47:0] r);
    @(posedge clk);
    rmsReq <= 1'b1;
    rmsData <= r;
    @(posedge clk);
    rmsReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send_rms

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_chk("control", `IOC_ADDR_CONTROL, 32'h0);
    rd_chk("threshold", `IOC_ADDR_THRESHOLD, 32'h000000C8);
    rd_chk("peak a", `IOC_ADDR_PEAK_A, 32'h0);
    rd_chk("unmapped", 8'h18, 32'h0);
    check("slverr", {31'h0, rerr}, 32'h1);
    // off mode: a large rms value gives no trip
    send_rms({16'h0000, 16'h0000, 16'h01F4});
    check_trips(4'h0);
    // peak mode: b sits exactly on the threshold, c is negative
    apb_xfer(1'b1, `IOC_ADDR_CONTROL, 32'h1);
    send_sample({16'hFED4, 16'h00C8, 16'h00C9});
    check_trips(4'hD);
    rd_chk("peak c", `IOC_ADDR_PEAK_C, 32'h0000012C);
    apb_xfer(1'b1, `IOC_ADDR_STATUS, 32'h0);
    rd_chk("status", `IOC_ADDR_STATUS, 32'h0000000D);
    // raising the threshold to the c peak clears every trip
    apb_xfer(1'b1, `IOC_ADDR_THRESHOLD, 32'h0000012C);
    settle();
    check_trips(4'h0);
    apb_xfer(1'b1, `IOC_ADDR_THRESHOLD, 32'h00000096);
    thresholdDoubleInput <= 1'b1;
    settle();
    check_trips(4'h0);
    thresholdDoubleInput <= 1'b0;
    settle();
    check_trips(4'hF);
    disableInput <= 1'b1;
    settle();
    check_trips(4'h0);
    rd_chk("status dis", `IOC_ADDR_STATUS, 32'h00000010);
    disableInput <= 1'b0;
    // fundamental mode ignores the stored peaks
    apb_xfer(1'b1, `IOC_ADDR_CONTROL, 32'h2);
    send_rms({16'h0000, 16'h0190, 16'h0064});
    check_trips(4'hA);
    // a frozen clock enable holds the trips even while disable rises
    ce <= 1'b0;
    disableInput <= 1'b1;
    settle();
    check_trips(4'hA);
    ce <= 1'b1;
    settle();
    check_trips(4'h0);
    disableInput <= 1'b0;
    settle();
    check_trips(4'hA);
    apb_xfer(1'b1, `IOC_ADDR_CONTROL, 32'h3);
    settle();
    check_trips(4'h0);
    apb_xfer(1'b1, `IOC_ADDR_THRESHOLD, 32'h00000005);
    rd_chk("thr low", `IOC_ADDR_THRESHOLD, 32'h00000014);
    apb_xfer(1'b1, `IOC_ADDR_THRESHOLD, 32'h00000FA0);
    rd_chk("thr high", `IOC_ADDR_THRESHOLD, 32'h00000BB8);
    // quiet samples age the old peaks out of both windows
    repeat (40) send_sample(48'h0);
    rd_chk("peak c aged", `IOC_ADDR_PEAK_C, 32'h0);
    // a reset in mid-run restores the mode and the start current
    apb_xfer(1'b1, `IOC_ADDR_CONTROL, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk("ctrl rst", `IOC_ADDR_CONTROL, 32'h0);
    rd_chk("thr rst", `IOC_ADDR_THRESHOLD, 32'h000000C8);
    finish_test();
  end
endmodule : test_three_phase_instant_overcurrent
